// file: design/swkt_tuning_ctrl.sv
// Sweep and knob tuning control with APB register access
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module swkt_tuning_ctrl
   import swkt_pkg::*;
(
   // APB slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Encoder and power detect
   input wire logic clockwise_phase,
   input wire logic counterclockwise_phase,
   input wire logic power_detect_active_n,
   // Timing inputs and sequencer
   input wire logic system_clock,
   input wire logic millisecond_clock,
   input wire logic slow_clock,
   input wire logic seq_code_zero,
   input wire logic [3:0] seq_state,
   input wire logic single_sweep_done,
   // Status outputs
   output logic add_direction,
   output logic manual_entry_flag,
   output logic sweep_active,
   output logic sweep_on_line,
   output logic fast_step_enable,
   output logic single_sweep_flag,
   output logic sweep_step_pulse,
   output logic hundred_step_select
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   function automatic logic in_state(input logic zero,
                                     input logic [3:0] st,
                                     input logic [3:0] want);
      in_state = zero & (st == want);
   endfunction

   function automatic logic rose_now(input logic cur, input logic prev);
      rose_now = cur & ~prev;
   endfunction

   logic [4:0] ctrl_reg;
   logic single_press_reg;
   logic sys_q_reg;
   logic ms_q_reg;
   logic slow_q_reg;
   logic quad_q_reg;
   logic mne_q_reg;
   logic step_stage_reg;
   logic pre_pass;

   // Decoded controls
   wire logic power_ok = power_detect_active_n;
   wire swkt_mode_t mode = swkt_mode_t'(ctrl_reg[SWKT_CTRL_MODE_LSB +: 2]);
   wire swkt_rate_t rate = swkt_rate_t'(ctrl_reg[SWKT_CTRL_RATE_LSB +: 2]);
   wire logic coarse = ctrl_reg[SWKT_CTRL_COARSE_BIT];
   wire logic mode_auto = (mode == SWKT_MODE_AUTO);
   wire logic mode_knob = (mode == SWKT_MODE_KNOB);
   wire logic mode_off = (mode == SWKT_MODE_OFF);
   wire logic mode_single = (mode == SWKT_MODE_SINGLE);

   // Clock edges of the slower timing inputs
   wire logic sys_rise = rose_now(system_clock, sys_q_reg);
   wire logic sys_fall = rose_now(sys_q_reg, system_clock);
   wire logic ms_rise = rose_now(millisecond_clock, ms_q_reg);
   wire logic slow_rise = rose_now(slow_clock, slow_q_reg);

   // Sequencer state decode
   wire logic st_idle = in_state(seq_code_zero, seq_state, SWKT_SEQ_IDLE);
   wire logic st_slow = in_state(seq_code_zero, seq_state, SWKT_SEQ_SLOW);
   wire logic st_reset = in_state(seq_code_zero, seq_state, SWKT_SEQ_RESET);
   wire logic st_fast = in_state(seq_code_zero, seq_state, SWKT_SEQ_FAST_A)
                      | in_state(seq_code_zero, seq_state, SWKT_SEQ_FAST_B)
                      | in_state(seq_code_zero, seq_state, SWKT_SEQ_FAST_C);

   // Encoder: both phases gated, their fall is one detent
   wire logic quad_and = clockwise_phase & counterclockwise_phase;
   wire logic quad_and_fell = quad_q_reg & ~quad_and;
   wire logic enc_evt = quad_and_fell & power_ok;

   swkt_prescale u_prescale (
      .pclk(pclk),
      .presetn(presetn),
      .divide_en(coarse),
      .event_in(enc_evt),
      .pass_out(pre_pass)
   );

   // APB decode
   wire logic setup = psel & ~penable;
   wire logic hit_ctrl = (paddr == SWKT_CTRL_OFF);
   wire logic hit_cmd = (paddr == SWKT_CMD_OFF);
   wire logic hit_stat = (paddr == SWKT_STAT_OFF);
   wire logic hit_any = hit_ctrl | hit_cmd | hit_stat;
   wire logic wr_done = psel & penable & pready & pwrite & ~pslverr;
   wire logic wr_ctrl = wr_done & hit_ctrl;
   wire logic wr_single = wr_done & hit_cmd & pwdata[SWKT_CMD_SINGLE_BIT];

   wire logic [31:0] status_word = {23'h000000,
      sweep_step_pulse, power_ok, sweep_on_line, hundred_step_select,
      add_direction, manual_entry_flag, fast_step_enable,
      single_sweep_flag, sweep_active};
   wire logic [31:0] ctrl_word = {27'h0000000, ctrl_reg};
   wire logic [31:0] rd_mux = hit_ctrl ? ctrl_word :
                              hit_stat ? status_word : 32'h00000000;

   // Manual entry flag: set wins over the state-eleven clear
   wire logic mne_clear = sys_fall & st_reset;
   wire logic mne_next = pre_pass | (manual_entry_flag & ~mne_clear);
   wire logic add_next = enc_evt ? ~clockwise_phase : add_direction;

   // Single sweep flag
   wire logic single_set = single_press_reg & mode_single & power_ok;
   wire logic done_clear = sys_fall & single_sweep_done;
   wire logic single_next = single_set | (single_sweep_flag & ~done_clear);

   // Sweep active JK flip-flop on the system clock
   wire logic sw_j = power_ok & (((mode_auto | mode_knob) & st_idle)
                               | single_sweep_flag);
   wire logic sw_k = mode_off;
   wire logic sweep_next = done_clear ? 1'b0 :
                           ~sys_rise ? sweep_active :
                           sw_k ? 1'b0 : sw_j ? 1'b1 : sweep_active;

   // Fast step enable
   wire logic fast_next = (sys_rise & ~power_ok) ? 1'b0 :
                          (sys_rise & st_fast) ? 1'b1 :
                          (sys_fall & st_slow) ? 1'b0 :
                          fast_step_enable;

   // Step clock source selection
   wire logic knob_rise = rose_now(manual_entry_flag, mne_q_reg);
   wire logic auto_src = (rate == SWKT_RATE_LOW) ? slow_rise :
                         ms_rise;
   wire logic step_src = fast_step_enable ? sys_rise :
                         ~sweep_on_line ? 1'b0 :
                         mode_knob ? knob_rise :
                         mode_auto ? auto_src : 1'b0;
   wire logic step_clear = sys_fall & (st_reset | st_slow);
   wire logic stage_next = step_clear ? 1'b0 :
                           step_src ? 1'b1 : step_stage_reg;
   wire logic pulse_next = step_clear ? 1'b0 :
                           sys_fall ? step_stage_reg :
                           sweep_step_pulse;
   wire logic hundred_next = mode_auto & (rate == SWKT_RATE_FAST);

   // APB slave registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= SWKT_CTRL_RESET;
         single_press_reg <= 1'b0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         if (wr_ctrl) begin
            ctrl_reg <= pwdata[4:0];
         end
         single_press_reg <= wr_single;
         pready <= setup;
         if (setup) begin
            pslverr <= ~hit_any;
            prdata <= rd_mux;
         end
      end
   end

   // Edge history
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sys_q_reg <= 1'b0;
         ms_q_reg <= 1'b0;
         slow_q_reg <= 1'b0;
         quad_q_reg <= 1'b0;
         mne_q_reg <= 1'b0;
      end else begin
         sys_q_reg <= system_clock;
         ms_q_reg <= millisecond_clock;
         slow_q_reg <= slow_clock;
         quad_q_reg <= quad_and;
         mne_q_reg <= manual_entry_flag;
      end
   end

   // Tuning and sweep state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         add_direction <= 1'b0;
         manual_entry_flag <= 1'b0;
         single_sweep_flag <= 1'b0;
         sweep_active <= 1'b0;
         sweep_on_line <= 1'b0;
         fast_step_enable <= 1'b0;
         step_stage_reg <= 1'b0;
         sweep_step_pulse <= 1'b0;
         hundred_step_select <= 1'b0;
      end else begin
         add_direction <= add_next;
         manual_entry_flag <= mne_next;
         single_sweep_flag <= single_next;
         sweep_active <= sweep_next;
         sweep_on_line <= sweep_active | single_sweep_flag;
         fast_step_enable <= fast_next;
         step_stage_reg <= stage_next;
         sweep_step_pulse <= pulse_next;
         hundred_step_select <= hundred_next;
      end
   end

   // Checks
   enc_add_a: assert property (
      enc_evt && !clockwise_phase |=> add_direction)
      else $error("clockwise detent did not select add");
   enc_sub_a: assert property (
      enc_evt && clockwise_phase |=> !add_direction)
      else $error("counterclockwise detent did not select subtract");
   power_block_a: assert property (
      !power_detect_active_n && !manual_entry_flag && !pre_pass
      |=> !manual_entry_flag)
      else $error("manual entry set during power detect");
   coarse_div_a: assert property (
      $rose(manual_entry_flag) |-> $past(pre_pass))
      else $error("manual entry set without prescaler pass");
   fast_hold_a: assert property (
      sys_rise && !power_detect_active_n |=> !fast_step_enable)
      else $error("fast step not held clear at power on");
   fast_set_a: assert property (
      sys_rise && power_detect_active_n && st_fast |=> fast_step_enable)
      else $error("fast step not set in states thirteen to fifteen");
   single_keep_a: assert property (
      single_sweep_flag && !single_sweep_done |=> single_sweep_flag)
      else $error("single sweep flag dropped before done");
   done_reset_a: assert property (
      done_clear && !single_set |=> !single_sweep_flag && !sweep_active)
      else $error("done did not reset single and sweep flags");
   step_sync_a: assert property (
      $rose(sweep_step_pulse) |-> $past(sys_fall) && $past(step_stage_reg))
      else $error("step pulse rose off the inverted system clock");
   step_reset_a: assert property (
      sys_fall && st_reset |=> !step_stage_reg && !sweep_step_pulse)
      else $error("state eleven did not clear step stages");
   hundred_sel_a: assert property (
      mode_auto && rate == SWKT_RATE_FAST |=> hundred_step_select)
      else $error("hundred step select missing at fast rate");

   // Power detect, sweep and single sweep flags
   power_sweep_a: assert property (
      !power_ok && !sweep_active |=> !sweep_active)
      else $error("sweep started during power detect");

   power_single_a: assert property (
      !power_ok && !single_sweep_flag |=> !single_sweep_flag)
      else $error("single sweep started during power detect");

   sweep_set_a: assert property (
      sys_rise && power_ok && (mode_auto || mode_knob) && st_idle
      |=> sweep_active)
      else $error("sweep not set in state zero");

   sweep_off_a: assert property (
      sys_rise && mode_off |=> !sweep_active)
      else $error("sweep off did not reset sweep flag");

   single_idle_a: assert property (
      !single_sweep_flag && !single_press_reg |=> !single_sweep_flag)
      else $error("single sweep flag set while quiescent");

   single_set_a: assert property (
      single_press_reg && mode_single && power_ok |=> single_sweep_flag)
      else $error("single press did not set single sweep flag");

   single_start_a: assert property (
      sys_rise && power_ok && single_sweep_flag && !mode_off
      |=> sweep_active)
      else $error("single sweep did not set sweep flag");

   // Step clock sources and step stages
   fast_step_a: assert property (
      fast_step_enable && sys_rise |=> step_stage_reg)
      else $error("system clock did not reach the step stage");

   slow_clear_a: assert property (
      sys_fall && st_slow
      |=> !fast_step_enable && !step_stage_reg && !sweep_step_pulse)
      else $error("state nine did not clear fast step and stages");

   mid_src_a: assert property (
      $rose(millisecond_clock) && mode_auto && rate == SWKT_RATE_MID
      && sweep_on_line && !fast_step_enable && !sys_fall
      |=> step_stage_reg)
      else $error("millisecond clock did not set step stage");

   low_src_a: assert property (
      $rose(slow_clock) && mode_auto && rate == SWKT_RATE_LOW
      && sweep_on_line && !fast_step_enable && !sys_fall
      |=> step_stage_reg)
      else $error("slow clock did not set step stage");

   low_only_a: assert property (
      mode_auto && rate == SWKT_RATE_LOW && !fast_step_enable
      && !slow_clock && !step_stage_reg |=> !step_stage_reg)
      else $error("step stage set at low rate without slow clock");

   knob_src_a: assert property (
      $rose(manual_entry_flag) && mode_knob && sweep_on_line
      && !fast_step_enable && !sys_fall |=> step_stage_reg)
      else $error("manual entry did not set step stage in knob mode");

   step_hold_a: assert property (
      sweep_step_pulse && !sys_fall |=> sweep_step_pulse)
      else $error("step pulse dropped off the inverted system clock");

   // Bus answer, hundred step select and direction
   ready_next_a: assert property (
      psel && !penable |=> pready)
      else $error("bus setup not answered in the next cycle");

   hundred_off_a: assert property (
      !(mode_auto && rate == SWKT_RATE_FAST) |=> !hundred_step_select)
      else $error("hundred step select outside fast automatic sweep");

   add_hold_a: assert property (
      !enc_evt |=> $stable(add_direction))
      else $error("add direction changed without a detent");
endmodule // swkt_tuning_ctrl
`default_nettype wire

// file: design/swkt_pkg.sv
// Constants and types for the sweep and knob tuning control
package swkt_pkg;
   // Register byte offsets
   localparam logic [11:0] SWKT_CTRL_OFF = 12'h000;
   localparam logic [11:0] SWKT_CMD_OFF = 12'h004;
   localparam logic [11:0] SWKT_STAT_OFF = 12'h008;
   // Control register fields
   localparam int SWKT_CTRL_MODE_LSB = 0;
   localparam int SWKT_CTRL_RATE_LSB = 2;
   localparam int SWKT_CTRL_COARSE_BIT = 4;
   localparam logic [31:0] SWKT_CTRL_MASK = 32'h0000001F;
   localparam logic [4:0] SWKT_CTRL_RESET = 5'h00;
   // Command register fields
   localparam int SWKT_CMD_SINGLE_BIT = 0;
   // Status register fields
   localparam int SWKT_ST_ACTIVE = 0;
   localparam int SWKT_ST_SINGLE = 1;
   localparam int SWKT_ST_FAST = 2;
   localparam int SWKT_ST_MANUAL = 3;
   localparam int SWKT_ST_ADD = 4;
   localparam int SWKT_ST_HUNDRED = 5;
   localparam int SWKT_ST_SWEEPON = 6;
   localparam int SWKT_ST_POWER = 7;
   localparam int SWKT_ST_STEP = 8;
   // Sequencer states within code zero
   localparam logic [3:0] SWKT_SEQ_IDLE = 4'h0;
   localparam logic [3:0] SWKT_SEQ_SLOW = 4'h9;
   localparam logic [3:0] SWKT_SEQ_RESET = 4'hB;
   localparam logic [3:0] SWKT_SEQ_FAST_A = 4'hD;
   localparam logic [3:0] SWKT_SEQ_FAST_B = 4'hE;
   localparam logic [3:0] SWKT_SEQ_FAST_C = 4'hF;
   // Encoder prescaler passes every fifth event
   localparam logic [2:0] SWKT_PRE_LAST = 3'h4;
   localparam logic [2:0] SWKT_PRE_ONE = 3'h1;
   localparam logic [2:0] SWKT_PRE_ZERO = 3'h0;
   // Sweep mode selection
   typedef enum logic [1:0] {
      SWKT_MODE_OFF = 2'b00,
      SWKT_MODE_AUTO = 2'b01,
      SWKT_MODE_KNOB = 2'b10,
      SWKT_MODE_SINGLE = 2'b11
   } swkt_mode_t;
   // Sweep rate selection
   typedef enum logic [1:0] {
      SWKT_RATE_LOW = 2'b00,
      SWKT_RATE_MID = 2'b01,
      SWKT_RATE_FAST = 2'b10,
      SWKT_RATE_SPARE = 2'b11
   } swkt_rate_t;
endpackage

// file: design/swkt_prescale.sv
// Divide-by-five prescaler for encoder entry events
`timescale 1ns/100ps
`default_nettype none
module swkt_prescale
   import swkt_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Event path
   input wire logic divide_en,
   input wire logic event_in,
   output logic pass_out
);
   logic [2:0] count_reg;
   logic [2:0] count_next;
   logic pass_next;
   wire logic at_last = (count_reg == SWKT_PRE_LAST);

   // Bypass when not dividing, else pass on the fifth event
   assign pass_next = event_in & (~divide_en | at_last);
   assign count_next = (~event_in | ~divide_en) ? count_reg :
                       at_last ? SWKT_PRE_ZERO : count_reg + SWKT_PRE_ONE;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_reg <= SWKT_PRE_ZERO;
         pass_out <= 1'b0;
      end else begin
         count_reg <= count_next;
         pass_out <= pass_next;
      end
   end
endmodule // swkt_prescale
`default_nettype wire

// file: testbench/swkt_partner.sv
// Encoder, step clock and sequencer model facing the tuning control
`timescale 1ns/100ps
`default_nettype none
module swkt_partner (
   // Clock
   input wire logic pclk,
   // Encoder phases
   output logic clockwise_phase,
   output logic counterclockwise_phase,
   // Timing sources and sequencer
   output logic system_clock,
   output logic millisecond_clock,
   output logic slow_clock,
   output logic seq_code_zero,
   output logic [3:0] seq_state
);
   int div_cnt = 0;
   initial begin
      clockwise_phase = 1'h0;
      counterclockwise_phase = 1'h0;
      system_clock = 1'h0;
      millisecond_clock = 1'h0;
      slow_clock = 1'h0;
      seq_code_zero = 1'h1;
      seq_state = 4'h0;
   end
   // Shortened system clock, four pclk per half period
   always @(posedge pclk) begin
      div_cnt <= (div_cnt == 3) ? 0 : div_cnt + 1;
      if (div_cnt == 3) begin
         system_clock <= ~system_clock;
      end
   end
   // One detent, phases a quarter cycle apart, order gives direction
   task automatic detent(input logic cw_dir);
      logic [7:0] seq;
      seq = cw_dir ? 8'hB4 : 8'h78;
      for (int i = 3; i >= 0; i--) begin
         @(posedge pclk);
         clockwise_phase <= seq[2*i+1];
         counterclockwise_phase <= seq[2*i];
         repeat (2) @(posedge pclk);
      end
   endtask
   // One step clock pulse; both sources stand low otherwise
   task automatic step_clk(input logic use_slow);
      @(posedge pclk);
      millisecond_clock <= ~use_slow;
      slow_clock <= use_slow;
      repeat (12) @(posedge pclk);
      millisecond_clock <= 1'h0;
      slow_clock <= 1'h0;
   endtask
   task automatic set_state(input logic [3:0] s);
      @(posedge pclk);
      seq_state <= s;
   endtask
   // Code zero selector active or not
   task automatic set_code(input logic z);
      @(posedge pclk);
      seq_code_zero <= z;
   endtask
endmodule // swkt_partner
`default_nettype wire

// file: testbench/swkt_tuning_ctrl_tb.sv
// Self-checking bench for the sweep and knob tuning control
`timescale 1ns/100ps
`default_nettype none
module swkt_tuning_ctrl_tb;
   import swkt_pkg::*;
   logic pclk, presetn;
   logic psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic pready, pslverr, err;
   logic power_detect_active_n, single_sweep_done;
   logic clockwise_phase, counterclockwise_phase, system_clock;
   logic millisecond_clock, slow_clock, seq_code_zero;
   logic [3:0] seq_state;
   logic add_direction, manual_entry_flag, sweep_active, sweep_on_line;
   logic fast_step_enable, single_sweep_flag, sweep_step_pulse;
   logic hundred_step_select;
   int n_fail = 0, tests_run = 0, cycles = 0;

   initial pclk = 1'h0;
   always #2 pclk = ~pclk;

   swkt_tuning_ctrl swkt_tuning_ctrl_i (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .clockwise_phase, .counterclockwise_phase, .power_detect_active_n,
      .system_clock, .millisecond_clock, .slow_clock, .seq_code_zero,
      .seq_state, .single_sweep_done, .add_direction, .manual_entry_flag,
      .sweep_active, .sweep_on_line, .fast_step_enable, .single_sweep_flag,
      .sweep_step_pulse, .hundred_step_select);

   swkt_partner swkt_partner_i (.pclk, .clockwise_phase,
      .counterclockwise_phase, .system_clock, .millisecond_clock,
      .slow_clock, .seq_code_zero, .seq_state);

   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         n_fail++;
         end_of_test();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic bit_is(input logic seen, input logic exp);
      check({31'h0, seen}, {31'h0, exp});
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // One APB transfer; request held until pready is seen high
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'h1);
      q = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask
   task automatic ctrl(input logic [31:0] d);
      apb(1'h1, SWKT_CTRL_OFF, d);
      cyc(20);
   endtask
   task automatic to_state(input logic [3:0] s);
      swkt_partner_i.set_state(s);
      cyc(20);
   endtask

   initial begin
      presetn <= 1'h0;
      psel <= 1'h0;
      penable <= 1'h0;
      pwrite <= 1'h0;
      paddr <= 12'h000;
      pwdata <= 32'h0;
      power_detect_active_n <= 1'h0;
      single_sweep_done <= 1'h0;
      cyc(4);
      presetn <= 1'h1;
      @(posedge pclk);
      apb(1'h0, SWKT_CTRL_OFF, 32'h0);
      check(q, 32'h0);
      apb(1'h0, 12'h00C, 32'h0);
      check({q[30:0], err}, 32'h1);
      // Controls inhibited while power detect runs
      swkt_partner_i.detent(1'h1);
      bit_is(manual_entry_flag, 1'h0);
      ctrl(32'h1);
      bit_is(sweep_active, 1'h0);
      to_state(SWKT_SEQ_FAST_A);
      bit_is(fast_step_enable, 1'h0);
      ctrl(32'h0);
      to_state(SWKT_SEQ_IDLE);
      power_detect_active_n <= 1'h1;
      swkt_partner_i.detent(1'h1);
      bit_is(add_direction, 1'h1);
      bit_is(manual_entry_flag, 1'h1);
      to_state(SWKT_SEQ_RESET);
      to_state(SWKT_SEQ_IDLE);
      swkt_partner_i.detent(1'h0);
      bit_is(add_direction, 1'h0);
      bit_is(manual_entry_flag, 1'h1);
      to_state(SWKT_SEQ_RESET);
      to_state(SWKT_SEQ_IDLE);
      // Coarse prescale from a fresh count
      presetn <= 1'h0;
      cyc(2);
      presetn <= 1'h1;
      ctrl(32'h10);
      repeat (4) swkt_partner_i.detent(1'h1);
      bit_is(manual_entry_flag, 1'h0);
      swkt_partner_i.detent(1'h1);
      bit_is(manual_entry_flag, 1'h1);
      to_state(SWKT_SEQ_RESET);
      to_state(SWKT_SEQ_IDLE);
      // Automatic sweep, middle then fast then low rate
      ctrl(32'h5);
      bit_is(sweep_active, 1'h1);
      bit_is(sweep_step_pulse, 1'h0);
      swkt_partner_i.step_clk(1'h0);
      cyc(20);
      apb(1'h0, SWKT_STAT_OFF, 32'h0);
      check(q, 32'h1D1);
      to_state(SWKT_SEQ_RESET);
      bit_is(sweep_step_pulse, 1'h0);
      to_state(SWKT_SEQ_IDLE);
      ctrl(32'h9);
      bit_is(hundred_step_select, 1'h1);
      swkt_partner_i.step_clk(1'h0);
      cyc(20);
      bit_is(sweep_step_pulse, 1'h1);
      to_state(SWKT_SEQ_RESET);
      to_state(SWKT_SEQ_IDLE);
      ctrl(32'h1);
      swkt_partner_i.step_clk(1'h0);
      cyc(20);
      bit_is(sweep_step_pulse, 1'h0);
      swkt_partner_i.step_clk(1'h1);
      cyc(20);
      bit_is(sweep_step_pulse, 1'h1);
      to_state(SWKT_SEQ_FAST_C);
      bit_is(fast_step_enable, 1'h1);
      to_state(SWKT_SEQ_SLOW);
      bit_is(fast_step_enable, 1'h0);
      bit_is(sweep_step_pulse, 1'h0);
      swkt_partner_i.set_code(1'h0);
      to_state(SWKT_SEQ_FAST_C);
      bit_is(fast_step_enable, 1'h0);
      swkt_partner_i.set_code(1'h1);
      to_state(SWKT_SEQ_IDLE);
      ctrl(32'h0);
      bit_is(sweep_active, 1'h0);
      // Single sweep start and end
      apb(1'h1, SWKT_CMD_OFF, 32'h1);
      cyc(20);
      bit_is(single_sweep_flag, 1'h0);
      ctrl(32'h3);
      bit_is(single_sweep_flag, 1'h0);
      bit_is(sweep_active, 1'h0);
      apb(1'h1, SWKT_CMD_OFF, 32'h1);
      cyc(20);
      bit_is(single_sweep_flag, 1'h1);
      bit_is(sweep_active, 1'h1);
      single_sweep_done <= 1'h1;
      cyc(20);
      bit_is(single_sweep_flag, 1'h0);
      bit_is(sweep_active, 1'h0);
      single_sweep_done <= 1'h0;
      // Knob sweep steps from the encoder
      ctrl(32'h2);
      bit_is(sweep_step_pulse, 1'h0);
      swkt_partner_i.detent(1'h1);
      cyc(20);
      bit_is(sweep_step_pulse, 1'h1);
      end_of_test();
   end
endmodule // swkt_tuning_ctrl_tb
`default_nettype wire
